// file: hdl/ipd_consts.vh
// Constants for the interrupt priority dispatch block.
// Included by ipd_top.v; definitions only.
`ifndef IPD_CONSTS_VH
`define IPD_CONSTS_VH
`define IPD_NUM_SLOTS      21
`define IPD_NUM_LEVELS     4
`define IPD_LVL_W          2
`define IPD_IDX_W          5
`define IPD_OPERAND_ONES   8'hff
// Service mode codes
`define IPD_MODE_VECTOR    2'h0
`define IPD_MODE_CTXSW     2'h1
`define IPD_MODE_MACRO     2'h2
// Dispatch kinds on o_kind
`define IPD_KIND_NONE      3'h0
`define IPD_KIND_MASKABLE  3'h1
`define IPD_KIND_NMI_PIN   3'h2
`define IPD_KIND_WATCHDOG  3'h3
`define IPD_KIND_BREAK     3'h4
`define IPD_KIND_BANK_BRK  3'h5
`define IPD_KIND_OPERAND   3'h6
// Vector table word addresses
`define IPD_VEC_BREAK      16'h003e
`define IPD_VEC_OPERAND    16'h003c
`define IPD_VEC_NMI_PIN    16'h0002
`define IPD_VEC_WATCHDOG   16'h0004
`define IPD_VEC_SLOT0      16'h0006
`define IPD_VEC_SLOT12     16'h0026
`define IPD_VEC_SLOT20     16'h0036
// Fixed save area within a register bank (frame word)
`define IPD_BANK_SAVE_OFS  4'h0
`define IPD_NMI_BANK       3'h7
`endif

// file: hdl/ipd_top.v
// Interrupt request arbitration and dispatch for a 16-bit core.
// Assumes requests are one-cycle pulses on i_clock; the nmi pin is async.
`timescale 1ns/1ps
`default_nettype none
`include "ipd_consts.vh"

module ipd_top #(
  parameter NSLOT = `IPD_NUM_SLOTS
) (
  // Clock and reset
  input  wire              i_clock,
  input  wire              i_rst,
  // Hardware request pulses
  input  wire [2:0]        i_timer_overflow_req,   // timer 0,1,4
  input  wire [6:0]        i_edge_input_req,       // edge inputs 0..6
  input  wire [3:0]        i_t0_capcomp_match_req, // timer-0 channels 0..3
  input  wire [1:0]        i_t1_compare_match_req,
  input  wire [1:0]        i_t4_compare_match_req,
  input  wire              i_serial0_rx_error_req,
  input  wire              i_serial0_rx_done_req,
  input  wire              i_sync_serial1_done_req,
  input  wire              i_serial0_tx_done_req,
  input  wire              i_serial2_rx_error_req,
  input  wire              i_serial2_rx_done_req,
  input  wire              i_sync_serial2_done_req,
  input  wire              i_serial2_tx_done_req,
  input  wire              i_conversion_done_req,
  input  wire              i_nmi_pin_edge,         // async pin level edge
  input  wire              i_watchdog_overflow_req,
  // Per-slot configuration, flattened
  input  wire [NSLOT-1:0]  i_mask,
  input  wire [2*NSLOT-1:0] i_level,               // 0 is highest
  input  wire [2*NSLOT-1:0] i_mode,
  input  wire [3*NSLOT-1:0] i_bank,
  // Software sources from core
  input  wire              i_break_instr,
  input  wire              i_bank_switch_break_instr,
  input  wire [2:0]        i_bank_break_bank,
  input  wire              i_guarded_write,        // standby_control, watchdog_mode_setting, instr_a
  input  wire [7:0]        i_operand_lo,
  input  wire [7:0]        i_operand_hi,
  // Core handshake
  input  wire              i_ack,
  input  wire              i_return,               // return from vectored/ctx handler
  input  wire              i_macro_done,
  // Dispatch outputs
  output reg               o_dispatch,
  output reg  [2:0]        o_kind,
  output reg  [1:0]        o_mode,
  output reg  [4:0]        o_slot,
  output reg  [15:0]       o_vector,
  output reg  [2:0]        o_bank,
  output reg               o_push_stack,
  output reg               o_save_bank,
  output reg               o_restore_stack,
  output reg               o_restore_bank,
  output reg               o_conv_start_trigger,
  output reg  [3:0]        o_capture_trigger,
  output reg  [2:0]        o_level_in_service,
  output reg               o_operand_error
);

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  // Vector word for each default slot
  function [15:0] slot_vector;
    input [4:0] s;
    begin
      // Slots 0..11 are contiguous; the table skips four words before slot 12
      if (s < 5'd12)
        slot_vector = `IPD_VEC_SLOT0 + {10'h000, s, 1'b0};
      else
        slot_vector = `IPD_VEC_SLOT12 + {10'h000, s - 5'd12, 1'b0};
    end
  endfunction

  // Nmi pin synchroniser, three stages
  reg [2:0] nmi_sync_q;
  reg       nmi_level_q;
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      nmi_sync_q  <= 3'h0;
      nmi_level_q <= 1'b0;
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], i_nmi_pin_edge};
      if (nmi_sync_q[1] == nmi_sync_q[2])
        nmi_level_q <= nmi_sync_q[2];
    end
  end
  wire nmi_rise = (nmi_sync_q[1] == nmi_sync_q[2]) && nmi_sync_q[2] && !nmi_level_q;

  // Shared slots merge both sources
  wire [NSLOT-1:0] raw_req = {
    i_conversion_done_req,                                   // 20
    i_serial2_tx_done_req,                                   // 19
    i_serial2_rx_done_req | i_sync_serial2_done_req,         // 18
    i_serial2_rx_error_req,                                  // 17
    i_serial0_tx_done_req,                                   // 16
    i_serial0_rx_done_req | i_sync_serial1_done_req,         // 15
    i_serial0_rx_error_req,                                  // 14
    i_t4_compare_match_req,                                  // 13,12
    i_t1_compare_match_req,                                  // 11,10
    i_edge_input_req[6:4],                                   // 9..7
    i_edge_input_req[3:0] | i_t0_capcomp_match_req,          // 6..3
    i_timer_overflow_req};                                   // 2..0

  reg [NSLOT-1:0] pend_q;
  reg             nmi_pend_q, wdt_pend_q, brk_pend_q, bbrk_pend_q, oper_pend_q;
  reg [2:0]       bbrk_bank_q;
  reg [1:0]       state_q;
  // Level stack: bit per level currently in service, bit 4 for nmi pin and watchdog
  reg [4:0]       isr_q;

  wire [NSLOT-1:0] sel_ready;
  reg  [4:0]       win_idx;
  reg              win_ok;
  reg  [2:0]       cur_lvl;
  reg  [2:0]       win_lvl;
  integer          k;
  integer          j;

  // Active service level: lowest number set in isr_q, 4 means none
  always @* begin
    cur_lvl = 3'd4;
    for (k = 3; k >= 0; k = k - 1)
      if (isr_q[k])
        cur_lvl = k[2:0];
  end

  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_ready
      // Macro service bypasses the level others need higher level
      assign sel_ready[g] = pend_q[g] && !i_mask[g] && !isr_q[4] &&
        ((i_mode[2*g+1:2*g] == `IPD_MODE_MACRO) ||
         ({1'b0, i_level[2*g+1:2*g]} < cur_lvl));
    end
  endgenerate

  // Lowest level number wins, then lowest slot index
  always @* begin
    win_ok  = 1'b0;
    win_idx = 5'd0;
    win_lvl = 3'd4;
    for (j = NSLOT - 1; j >= 0; j = j - 1)
      if (sel_ready[j] && ({1'b0, i_level[2*j+:2]} <= win_lvl)) begin
        win_ok  = 1'b1;
        win_idx = j[4:0];
        win_lvl = {1'b0, i_level[2*j+:2]};
      end
  end

  wire oper_bad = i_guarded_write &&
    ((i_operand_lo ^ i_operand_hi) != `IPD_OPERAND_ONES);

  reg [NSLOT-1:0] clr_slot;
  always @* begin
    clr_slot = {NSLOT{1'b0}};
    if (state_q == ST_IDLE && !(nmi_pend_q | wdt_pend_q | oper_pend_q |
        brk_pend_q | bbrk_pend_q) && win_ok)
      clr_slot[win_idx] = 1'b1;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= {NSLOT{1'b0}};
      nmi_pend_q <= 1'b0;
      wdt_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
      bbrk_pend_q <= 1'b0;
      oper_pend_q <= 1'b0;
      bbrk_bank_q <= 3'h0;
      state_q <= ST_IDLE;
      isr_q <= 5'h00;
      o_dispatch <= 1'b0;
      o_kind <= `IPD_KIND_NONE;
      o_mode <= `IPD_MODE_VECTOR;
      o_slot <= 5'h00;
      o_vector <= 16'h0000;
      o_bank <= 3'h0;
      o_push_stack <= 1'b0;
      o_save_bank <= 1'b0;
      o_restore_stack <= 1'b0;
      o_restore_bank <= 1'b0;
      o_conv_start_trigger <= 1'b0;
      o_capture_trigger <= 4'h0;
      o_level_in_service <= 3'd4;
      o_operand_error <= 1'b0;
    end else begin
      // New requests win over the clear of the same cycle
      pend_q <= (pend_q & ~clr_slot) | raw_req;
      o_conv_start_trigger <= i_edge_input_req[4];
      o_capture_trigger <= i_edge_input_req[3:0];
      o_operand_error <= oper_bad;
      o_level_in_service <= cur_lvl;
      o_restore_stack <= 1'b0;
      o_restore_bank <= 1'b0;
      if (i_return) begin
        // Pop innermost level; restore from where the latest dispatch saved (o_save_bank)
        if (isr_q[4])
          isr_q[4] <= 1'b0;
        else if (cur_lvl != 3'd4)
          isr_q[cur_lvl[1:0]] <= 1'b0;
        o_restore_stack <= !o_save_bank;
        o_restore_bank <= o_save_bank;
      end
      case (state_q)
        ST_IDLE: begin
          nmi_pend_q <= nmi_pend_q | nmi_rise;
          wdt_pend_q <= wdt_pend_q | i_watchdog_overflow_req;
          brk_pend_q <= brk_pend_q | i_break_instr;
          oper_pend_q <= oper_pend_q | oper_bad;
          if (i_bank_switch_break_instr) begin
            bbrk_pend_q <= 1'b1;
            bbrk_bank_q <= i_bank_break_bank;
          end
          o_dispatch <= 1'b1;
          o_mode <= `IPD_MODE_VECTOR;
          o_push_stack <= 1'b1;
          o_save_bank <= 1'b0;
          state_q <= ST_WAIT;
          if (nmi_pend_q) begin
            nmi_pend_q <= nmi_rise;
            o_kind <= `IPD_KIND_NMI_PIN;
            o_vector <= `IPD_VEC_NMI_PIN;
            isr_q[4] <= 1'b1;
          end else if (wdt_pend_q) begin
            wdt_pend_q <= i_watchdog_overflow_req;
            o_kind <= `IPD_KIND_WATCHDOG;
            o_vector <= `IPD_VEC_WATCHDOG;
            isr_q[4] <= 1'b1;
          end else if (oper_pend_q) begin
            oper_pend_q <= oper_bad;
            o_kind <= `IPD_KIND_OPERAND;
            o_vector <= `IPD_VEC_OPERAND;
          end else if (brk_pend_q) begin
            brk_pend_q <= i_break_instr;
            o_kind <= `IPD_KIND_BREAK;
            o_vector <= `IPD_VEC_BREAK;
          end else if (bbrk_pend_q) begin
            bbrk_pend_q <= i_bank_switch_break_instr;
            o_kind <= `IPD_KIND_BANK_BRK;
            o_mode <= `IPD_MODE_CTXSW;
            o_bank <= bbrk_bank_q;
            o_vector <= 16'h0000;
            o_push_stack <= 1'b0;
            o_save_bank <= 1'b1;
          end else if (win_ok) begin
            o_kind <= `IPD_KIND_MASKABLE;
            o_slot <= win_idx;
            o_mode <= i_mode[2*win_idx+:2];
            o_bank <= i_bank[3*win_idx+:3];
            case (i_mode[2*win_idx+:2])
              `IPD_MODE_CTXSW: begin
                o_vector <= 16'h0000;
                o_push_stack <= 1'b0;
                o_save_bank <= 1'b1;
                isr_q[win_lvl[1:0]] <= 1'b1;
              end
              `IPD_MODE_MACRO: begin
                o_vector <= 16'h0000;
                o_push_stack <= 1'b0;
                o_save_bank <= 1'b0;
              end
              default: begin
                o_vector <= slot_vector(win_idx);
                isr_q[win_lvl[1:0]] <= 1'b1;
              end
            endcase
          end else begin
            o_dispatch <= 1'b0;
            o_push_stack <= 1'b0;
            // Keep the save kind so a late return restores from the right place
            o_save_bank <= o_save_bank;
            state_q <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          nmi_pend_q <= nmi_pend_q | nmi_rise;
          wdt_pend_q <= wdt_pend_q | i_watchdog_overflow_req;
          brk_pend_q <= brk_pend_q | i_break_instr;
          oper_pend_q <= oper_pend_q | oper_bad;
          if (i_bank_switch_break_instr) begin
            bbrk_pend_q <= 1'b1;
            bbrk_bank_q <= i_bank_break_bank;
          end
          // Macro service holds dispatch until firmware finishes
          if ((o_mode == `IPD_MODE_MACRO && o_kind == `IPD_KIND_MASKABLE) ?
              i_macro_done : i_ack) begin
            o_dispatch <= 1'b0;
            o_push_stack <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // ipd_top
`default_nettype wire

// file: sim/ipd_core_model.sv
// Core model for ipd_top: takes each dispatch after a set delay.
// Macro dispatches end with a done pulse, all others with an acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "ipd_consts.vh"
module ipd_core_model (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Dispatch from the block
  input  wire logic       i_dispatch,
  input  wire logic [2:0] i_kind,
  input  wire logic [1:0] i_mode,
  input  wire logic [3:0] i_delay,
  // Answers to the block
  output var  logic       o_ack,
  output var  logic       o_macro_done
);
  logic [3:0] wait_q;
  wire logic  due = i_dispatch && !o_ack && !o_macro_done && wait_q == i_delay;
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wait_q       <= 4'h0;
      o_ack        <= 1'b0;
      o_macro_done <= 1'b0;
    end else begin
      // Slow answers keep the dispatch fields standing longer
      o_ack        <= due && !(i_mode == `IPD_MODE_MACRO && i_kind == `IPD_KIND_MASKABLE);
      o_macro_done <= due && i_mode == `IPD_MODE_MACRO && i_kind == `IPD_KIND_MASKABLE;
      if (i_dispatch && !o_ack && !o_macro_done)
        wait_q <= due ? 4'h0 : wait_q + 4'h1;
    end
  end
endmodule // ipd_core_model
`default_nettype wire

// file: sim/ipd_top_chk.sv
// Checker for ipd_top: dispatch fields, modes, triggers and operand error.
// Bound to every ipd_top instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "ipd_consts.vh"
module ipd_top_chk #(
  parameter NSLOT = 21
) (
  input wire logic               i_clock,
  input wire logic               i_rst,
  input wire logic [6:0]         i_edge_input_req,
  input wire logic [3*NSLOT-1:0] i_bank,
  input wire logic               i_guarded_write,
  input wire logic [7:0]         i_operand_lo,
  input wire logic [7:0]         i_operand_hi,
  input wire logic               i_ack,
  input wire logic               i_macro_done,
  input wire logic               o_dispatch,
  input wire logic [2:0]         o_kind,
  input wire logic [1:0]         o_mode,
  input wire logic [4:0]         o_slot,
  input wire logic [15:0]        o_vector,
  input wire logic [2:0]         o_bank,
  input wire logic               o_push_stack,
  input wire logic               o_save_bank,
  input wire logic               o_conv_start_trigger,
  input wire logic [3:0]         o_capture_trigger,
  input wire logic               o_operand_error
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic mv = o_dispatch && o_kind == `IPD_KIND_MASKABLE;
  // Vector table skips four words between slot 11 and slot 12
  wire logic [15:0] exp_vec = {10'h0, o_slot, 1'b0} + ((o_slot < 5'd12) ? 16'h6 : 16'he);
  AST_STANDS: assert property (o_dispatch && !i_ack && !i_macro_done |=> o_dispatch
    && $stable(o_kind) && $stable(o_slot) && $stable(o_vector)) else $error("dispatch moved");
  AST_VECTOR: assert property (mv && o_mode == `IPD_MODE_VECTOR |-> o_vector == exp_vec)
    else $error("wrong vector");
  AST_PUSH: assert property (mv && o_mode == `IPD_MODE_VECTOR |-> o_push_stack && !o_save_bank)
    else $error("vectored save wrong");
  AST_CTX: assert property (mv && o_mode == `IPD_MODE_CTXSW |-> o_save_bank && !o_push_stack
    && o_bank == i_bank[3*o_slot +: 3]) else $error("context save wrong");
  AST_MACRO: assert property (mv && o_mode == `IPD_MODE_MACRO |-> !o_push_stack && !o_save_bank)
    else $error("macro touched state");
  AST_NMI: assert property (o_dispatch && o_kind == `IPD_KIND_NMI_PIN |-> o_vector == 16'h0002)
    else $error("pin vector wrong");
  AST_OPERAND: assert property (1'b1 |=> o_operand_error == ($past(i_guarded_write) &&
    ($past(i_operand_lo) ^ $past(i_operand_hi)) != 8'hff)) else $error("operand error wrong");
  AST_TRIG: assert property (o_capture_trigger == $past(i_edge_input_req[3:0]) &&
    o_conv_start_trigger == $past(i_edge_input_req[4])) else $error("trigger copy wrong");
endmodule // ipd_top_chk
bind ipd_top ipd_top_chk #(.NSLOT(NSLOT)) u_chk (.i_clock, .i_rst, .i_edge_input_req, .i_bank,
  .i_guarded_write, .i_operand_lo, .i_operand_hi, .i_ack, .i_macro_done, .o_dispatch, .o_kind,
  .o_mode, .o_slot, .o_vector, .o_bank, .o_push_stack, .o_save_bank, .o_conv_start_trigger,
  .o_capture_trigger, .o_operand_error);
`default_nettype wire

// file: sim/interrupt_priority_dispatch_bench.sv
// Testbench for ipd_top: source map, ordering, nesting, modes, software sources.
// Uses ipd_core_model as the core; the checker is bound to the block.
`timescale 1ns/1ps
`default_nettype none
`include "ipd_consts.vh"
module interrupt_priority_dispatch_bench;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [26:0] req = '0;
  logic [20:0] i_mask = '0;
  logic [41:0] i_level = '0;
  logic [41:0] i_mode = '0;
  logic [62:0] i_bank = '0;
  logic        nmi = 0, wdt = 0, brk = 0, bbrk = 0, gw = 0, i_return = 0;
  logic [2:0]  bbank = 3'h0;
  logic [7:0]  op_lo = 8'h0, op_hi = 8'h0;
  logic [3:0]  delay = 4'h0;
  wire logic        i_ack, i_macro_done, o_dispatch, o_save_bank, o_restore_bank, o_operand_error;
  wire logic        o_restore_stack;
  wire logic [2:0]  o_kind, o_bank, o_level_in_service;
  wire logic [1:0]  o_mode;
  wire logic [4:0]  o_slot;
  wire logic [15:0] o_vector;
  int err_count = 0, cmp_count = 0;
  localparam logic [2:0] MSK = `IPD_KIND_MASKABLE;
  always #2 i_clock = ~i_clock;
  ipd_top u_dut (.i_clock, .i_rst, .i_timer_overflow_req(req[2:0]), .i_edge_input_req(req[9:3]),
    .i_t0_capcomp_match_req(req[13:10]), .i_t1_compare_match_req(req[15:14]),
    .i_t4_compare_match_req(req[17:16]), .i_serial0_rx_error_req(req[18]),
    .i_serial0_rx_done_req(req[19]), .i_sync_serial1_done_req(req[20]),
    .i_serial0_tx_done_req(req[21]), .i_serial2_rx_error_req(req[22]),
    .i_serial2_rx_done_req(req[23]), .i_sync_serial2_done_req(req[24]),
    .i_serial2_tx_done_req(req[25]), .i_conversion_done_req(req[26]), .i_nmi_pin_edge(nmi),
    .i_watchdog_overflow_req(wdt), .i_mask, .i_level, .i_mode, .i_bank, .i_break_instr(brk),
    .i_bank_switch_break_instr(bbrk), .i_bank_break_bank(bbank), .i_guarded_write(gw),
    .i_operand_lo(op_lo), .i_operand_hi(op_hi), .i_ack, .i_return, .i_macro_done, .o_dispatch,
    .o_kind, .o_mode, .o_slot, .o_vector, .o_bank, .o_push_stack(), .o_save_bank,
    .o_restore_stack, .o_restore_bank, .o_conv_start_trigger(), .o_capture_trigger(),
    .o_level_in_service, .o_operand_error);
  ipd_core_model u_core (.i_clock, .i_rst, .i_dispatch(o_dispatch), .i_kind(o_kind),
    .i_mode(o_mode), .i_delay(delay), .o_ack(i_ack), .o_macro_done(i_macro_done));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] vec_of(input int s);
    return (s < 12) ? 16'(6 + 2 * s) : 16'(14 + 2 * s);
  endfunction
  task automatic pulse(input int b);
    req[b] = 1'b1;
    tick();
    req[b] = 1'b0;
  endtask
  task automatic ret;
    i_return = 1'b1;
    tick();
    i_return = 1'b0;
    tick();
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      tick();
      chk("no dispatch", 16'h0, 16'(o_dispatch));
    end
  endtask
  // Waits for a dispatch, judges it, lets the core model take it
  task automatic serve(input logic [2:0] k, input int s, input logic [15:0] v, input bit r);
    int n;
    for (n = 0; n < 30 && o_dispatch !== 1'b1; n++) tick();
    chk("dispatch", 16'h1, 16'(o_dispatch));
    if (n == 30) conclude();
    chk("kind", 16'(k), 16'(o_kind));
    if (k == MSK) chk("slot", 16'(s), 16'(o_slot));
    chk("vector", v, o_vector);
    for (n = 0; n < 30 && o_dispatch !== 1'b0; n++) tick();
    chk("released", 16'h0, 16'(o_dispatch));
    if (n == 30) conclude();
    if (r) ret();
  endtask
  task automatic t_map;
    int slot_of[27] = '{0,1,2,3,4,5,6,7,8,9,3,4,5,6,10,11,12,13,14,15,15,16,17,18,18,19,20};
    for (int i = 0; i < 27; i++) begin
      pulse(i);
      serve(MSK, slot_of[i], vec_of(slot_of[i]), 1);
    end
  endtask
  task automatic t_order;
    delay = 4'h3;
    req = 27'h482_0000;
    tick();
    req = '0;
    serve(MSK, 13, vec_of(13), 1);
    serve(MSK, 18, vec_of(18), 1);
    serve(MSK, 20, vec_of(20), 1);
    i_level = {{2'h0}, {20{2'h3}}};
    req = 27'h482_0000;
    tick();
    req = '0;
    serve(MSK, 20, vec_of(20), 1);
    serve(MSK, 13, vec_of(13), 1);
    serve(MSK, 18, vec_of(18), 1);
    i_level = '0;
  endtask
  task automatic t_nest;
    i_level[5:0] = 6'h1a;
    pulse(0);
    serve(MSK, 0, vec_of(0), 0);
    chk("level in service", 16'h2, 16'(o_level_in_service));
    pulse(1);
    quiet(6);
    pulse(2);
    serve(MSK, 2, vec_of(2), 1);
    quiet(4);
    i_return = 1'b1;
    tick();
    i_return = 1'b0;
    chk("stack restore", 16'h1, 16'(o_restore_stack));
    chk("bank restore", 16'h0, 16'(o_restore_bank));
    tick();
    serve(MSK, 1, vec_of(1), 1);
    chk("level idle", 16'h4, 16'(o_level_in_service));
    i_level = '0;
  endtask
  task automatic t_modes;
    i_mode[41:40] = 2'h2;
    i_level[41:40] = 2'h3;
    pulse(0);
    serve(MSK, 0, vec_of(0), 0);
    pulse(26);
    serve(MSK, 20, 16'h0, 0);
    chk("level in service", 16'h0, 16'(o_level_in_service));
    ret();
    i_mode = '0;
    i_mode[11:10] = 2'h1;
    i_bank[17:15] = 3'h3;
    pulse(5);
    serve(MSK, 5, 16'h0, 0);
    chk("bank", 16'h3, 16'(o_bank));
    tick();
    i_return = 1'b1;
    tick();
    chk("bank restore", 16'h1, 16'(o_restore_bank));
    i_return = 1'b0;
    bbank = 3'h5;
    bbrk = 1'b1;
    tick();
    bbrk = 1'b0;
    serve(`IPD_KIND_BANK_BRK, 0, 16'h0, 0);
    chk("bank", 16'h5, 16'(o_bank));
    ret();
    i_mode = '0;
  endtask
  task automatic t_soft;
    {op_lo, op_hi} = 16'h5aa5;
    gw = 1'b1;
    tick();
    gw = 1'b0;
    chk("operand error", 16'h0, 16'(o_operand_error));
    quiet(4);
    op_hi = 8'h5b;
    gw = 1'b1;
    tick();
    gw = 1'b0;
    chk("operand error", 16'h1, 16'(o_operand_error));
    serve(`IPD_KIND_OPERAND, 0, 16'h003c, 1);
    brk = 1'b1;
    tick();
    brk = 1'b0;
    serve(`IPD_KIND_BREAK, 0, 16'h003e, 1);
    wdt = 1'b1;
    tick();
    wdt = 1'b0;
    serve(`IPD_KIND_WATCHDOG, 0, 16'h0004, 1);
    i_mask[3] = 1'b1;
    pulse(3);
    nmi = 1'b1;
    serve(`IPD_KIND_NMI_PIN, 0, 16'h0002, 1);
    quiet(3);
    i_mask = '0;
    serve(MSK, 3, vec_of(3), 1);
  endtask
  initial begin
    tick(4);
    i_rst = 1'b0;
    chk("level idle", 16'h4, 16'(o_level_in_service));
    t_map();
    t_order();
    t_nest();
    t_modes();
    t_soft();
    conclude();
  end
endmodule // interrupt_priority_dispatch_bench
`default_nettype wire
